/* mri_defs.svh */
`ifndef MRI_DEFS_SVH
`define MRI_DEFS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define MRI_IDX_W            5
`define MRI_IDX_PORT5_DIR    5'h05
`define MRI_IDX_PORT6_DIR    5'h06
`define MRI_IDX_PORT7_DIR    5'h07
`define MRI_IDX_PORT8_DIR    5'h08
`define MRI_IDX_RAM_PTR      5'h09
`define MRI_IDX_RAM_WIN      5'h0A
`define MRI_IDX_CNT1_PER     5'h0B
`define MRI_IDX_CNT2_PER     5'h0C
`define MRI_IDX_HPW_PER      5'h0D
`define MRI_IDX_LPW_PER      5'h0E
`define MRI_IDX_INT_MASK     5'h0F
`define MRI_IDX_CAUSE        5'h11
`define MRI_IDX_CPU_BITS     5'h12
`define MRI_IDX_WAKE_CTL     5'h16
`define MRI_IDX_TMR_CTL      5'h17
`define MRI_IDX_WDT_CTL      5'h18

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define MRI_PORT5_RST        8'hF0
`define MRI_PORT_DIR_RST     8'hFF
`define MRI_ZERO_RST         8'h00
`define MRI_TMR_CTL_RST      8'hBF
`define MRI_TMR_INT_BIT      6
`define MRI_WAKE_CTL_MASK    8'h8F
`define MRI_WDT_CTL_RST      8'h07
`define MRI_WDT_CTL_MASK     8'h0F
`define MRI_WDT_EN_BIT       3
`define MRI_CPU_BITS_RST     4'h0

`endif

/* mri_pkg.sv */
package mri_pkg;

	// ----------------------------------------
	// reset cause
	// ----------------------------------------
	typedef enum logic [1:0] {
		MRI_CAUSE_POR  = 2'b00,
		MRI_CAUSE_PIN  = 2'b01,
		MRI_CAUSE_WDT  = 2'b10,
		MRI_CAUSE_WAKE = 2'b11
	} mri_cause_t;

endpackage : mri_pkg

/* mri_reset_sync.sv */
`timescale 1ns/1ps

// ----------------------------------------
// reset synchroniser: asserts at once, releases after two edges
// ----------------------------------------
module mri_reset_sync (
	input  wire logic mclk,
	input  wire logic srcActive,
	output logic      resetOutB
);

	logic stage1Reg;
	logic stage1Next;
	logic stage2Reg;
	logic stage2Next;

	always_comb begin
		stage1Next = 1'b1;
		stage2Next = stage1Reg;
	end

	// release is clean because the stages only shift in a constant
	always_ff @(posedge mclk or posedge srcActive) begin
		if (srcActive) begin
			stage1Reg <= 1'b0;
			stage2Reg <= 1'b0;
		end else begin
			stage1Reg <= stage1Next;
			stage2Reg <= stage2Next;
		end
	end

	assign resetOutB = stage2Reg;

endmodule : mri_reset_sync

/* mri_reset_initializer.sv */
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`include "mri_defs.svh"

// Summary of operation
// - reset from power-on, watchdog or pin
// - watchdog resets only while enabled
// - low reset pin performs warm reset
// - power-on reset cannot be masked
// - oscillator kept running during reset
// - program counter cleared to zero
// - all port pins become inputs (port 5 loads F0, its bits 3:0 cleared)
// - time counter, watchdog, prescaler cleared
// - power-on only clears reg three/four bits
// - timer control all ones, interrupt flag cleared
// - registers initialised; pin-change wake keeps them
module mri_reset_initializer (
	input  wire logic                mclk,
	input  wire logic                rst_b,
	input  wire logic                porDetect,
	input  wire logic                resetPinB,
	input  wire logic                wdtTimeout,
	input  wire logic                pinChangeWake,
	input  wire logic                timerIntEvent,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	output logic                     coreResetB,
	output logic                     programCounterClear,
	output logic                     counterClear,
	output logic                     oscRunForce,
	output logic                     wakeRestart,
	output mri_pkg::mri_cause_t      resetCause,
	output logic      [7:0]          port5DirReg,
	output logic      [7:0]          port6DirReg,
	output logic      [7:0]          port7DirReg,
	output logic      [7:0]          port8DirReg,
	output logic      [7:0]          wakeupControlReg,
	output logic      [7:0]          timerControlReg,
	output logic      [7:0]          interruptMaskReg,
	output logic                     watchdogEnable,
	output logic      [1:0]          cpuRegThreeBits,
	output logic      [1:0]          cpuRegFourBits
);
	import mri_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] wrByte(input logic [7:0] oldVal, input logic hit,
		input logic [7:0] newVal);
		wrByte = hit ? newVal : oldVal;
	endfunction : wrByte

	// ----------------------------------------
	// source synchronisers and reset merge
	// ----------------------------------------
	logic pinMeta;
	logic pinSync;
	logic wdtMeta;
	logic wdtSync;
	logic wdtReqReg;
	logic wdtReqNext;
	logic porSrc;
	logic anySrc;
	logic porRstB;
	logic anyRstB;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pinMeta <= 1'b1;
			pinSync <= 1'b1;
			wdtMeta <= 1'b0;
			wdtSync <= 1'b0;
		end else begin
			pinMeta <= resetPinB;
			pinSync <= pinMeta;
			wdtMeta <= wdtTimeout;
			wdtSync <= wdtMeta;
		end
	end

	// power-on path bypasses every register bit so nothing can mask it
	assign porSrc = porDetect | ~rst_b;
	assign anySrc = porSrc | ~pinSync | wdtReqReg;

	mri_reset_sync porSyncInst (
		.mclk      (mclk),
		.srcActive (porSrc),
		.resetOutB (porRstB)
	);

	mri_reset_sync anySyncInst (
		.mclk      (mclk),
		.srcActive (anySrc),
		.resetOutB (anyRstB)
	);

	assign coreResetB          = anyRstB;
	assign programCounterClear = ~anyRstB;
	assign counterClear        = ~anyRstB;
	assign oscRunForce         = ~anyRstB;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic [`MRI_IDX_W-1:0] idx;
	logic                  wrHit;
	logic                  ackReg;
	logic                  ackNext;
	logic [7:0]            rdByte;
	logic [31:0]           rdataReg;
	logic [31:0]           rdataNext;
	logic [7:0]            wdtControlReg;
	logic [7:0]            ramPointerReg;
	logic [7:0]            cnt1PeriodReg;
	logic [7:0]            cnt2PeriodReg;
	logic [7:0]            hpPeriodReg;
	logic [7:0]            lpPeriodReg;
	logic [7:0]            ramWindowReg;
	logic [3:0]            cpuBitsReg;
	mri_cause_t            causeReg;

	assign idx   = wb_adr_i[6:2];
	// a write lands on the edge where the master sees ack
	assign wrHit = wb_cyc_i & wb_stb_i & wb_we_i & ackReg & wb_sel_i[0];

	always_comb begin
		case (idx)
			`MRI_IDX_PORT5_DIR: rdByte = port5DirReg;
			`MRI_IDX_PORT6_DIR: rdByte = port6DirReg;
			`MRI_IDX_PORT7_DIR: rdByte = port7DirReg;
			`MRI_IDX_PORT8_DIR: rdByte = port8DirReg;
			`MRI_IDX_RAM_PTR:   rdByte = ramPointerReg;
			`MRI_IDX_RAM_WIN:   rdByte = ramWindowReg;
			`MRI_IDX_CNT1_PER:  rdByte = cnt1PeriodReg;
			`MRI_IDX_CNT2_PER:  rdByte = cnt2PeriodReg;
			`MRI_IDX_HPW_PER:   rdByte = hpPeriodReg;
			`MRI_IDX_LPW_PER:   rdByte = lpPeriodReg;
			`MRI_IDX_INT_MASK:  rdByte = interruptMaskReg;
			`MRI_IDX_CAUSE:     rdByte = {6'h00, causeReg};
			`MRI_IDX_CPU_BITS:  rdByte = {4'h0, cpuBitsReg};
			`MRI_IDX_WAKE_CTL:  rdByte = wakeupControlReg;
			`MRI_IDX_TMR_CTL:   rdByte = timerControlReg;
			`MRI_IDX_WDT_CTL:   rdByte = wdtControlReg;
			default:            rdByte = 8'h00;
		endcase
		ackNext   = wb_cyc_i & wb_stb_i & ~ackReg;
		rdataNext = ackNext ? {24'h000000, rdByte} : rdataReg;
	end

	assign wb_ack_o = ackReg;
	assign wb_dat_o = rdataReg;

	// ----------------------------------------
	// registers initialised by every reset
	// ----------------------------------------
	logic [7:0] port5DirNext;
	logic [7:0] port6DirNext;
	logic [7:0] port7DirNext;
	logic [7:0] port8DirNext;
	logic [7:0] wakeCtlNext;
	logic [7:0] tmrCtlNext;
	logic [7:0] intMaskNext;
	logic [7:0] wdtCtlNext;
	logic [7:0] ramPtrNext;
	logic [7:0] cnt1Next;
	logic [7:0] cnt2Next;
	logic [7:0] hpNext;
	logic [7:0] lpNext;
	logic       wakeRestartReg;
	logic       wakeRestartNext;

	always_comb begin
		port5DirNext = wrByte(port5DirReg, wrHit && idx == `MRI_IDX_PORT5_DIR, wb_dat_i[7:0]);
		port6DirNext = wrByte(port6DirReg, wrHit && idx == `MRI_IDX_PORT6_DIR, wb_dat_i[7:0]);
		port7DirNext = wrByte(port7DirReg, wrHit && idx == `MRI_IDX_PORT7_DIR, wb_dat_i[7:0]);
		port8DirNext = wrByte(port8DirReg, wrHit && idx == `MRI_IDX_PORT8_DIR, wb_dat_i[7:0]);
		ramPtrNext   = wrByte(ramPointerReg, wrHit && idx == `MRI_IDX_RAM_PTR, wb_dat_i[7:0]);
		cnt1Next     = wrByte(cnt1PeriodReg, wrHit && idx == `MRI_IDX_CNT1_PER, wb_dat_i[7:0]);
		cnt2Next     = wrByte(cnt2PeriodReg, wrHit && idx == `MRI_IDX_CNT2_PER, wb_dat_i[7:0]);
		hpNext       = wrByte(hpPeriodReg, wrHit && idx == `MRI_IDX_HPW_PER, wb_dat_i[7:0]);
		lpNext       = wrByte(lpPeriodReg, wrHit && idx == `MRI_IDX_LPW_PER, wb_dat_i[7:0]);
		intMaskNext  = wrByte(interruptMaskReg, wrHit && idx == `MRI_IDX_INT_MASK,
			wb_dat_i[7:0]);
		wakeCtlNext  = wrByte(wakeupControlReg, wrHit && idx == `MRI_IDX_WAKE_CTL,
			wb_dat_i[7:0] & `MRI_WAKE_CTL_MASK);
		wdtCtlNext   = wrByte(wdtControlReg, wrHit && idx == `MRI_IDX_WDT_CTL,
			wb_dat_i[7:0] & `MRI_WDT_CTL_MASK);
		tmrCtlNext   = timerControlReg;
		if (wrHit && idx == `MRI_IDX_TMR_CTL) begin
			// software may only clear the interrupt flag
			tmrCtlNext = wb_dat_i[7:0];
			tmrCtlNext[`MRI_TMR_INT_BIT] = timerControlReg[`MRI_TMR_INT_BIT]
				& wb_dat_i[`MRI_TMR_INT_BIT];
		end
		if (timerIntEvent) begin
			tmrCtlNext[`MRI_TMR_INT_BIT] = 1'b1;
		end
		wakeRestartNext = pinChangeWake;
	end

	always_ff @(posedge mclk or negedge anyRstB) begin
		if (!anyRstB) begin
			port5DirReg      <= `MRI_PORT5_RST;
			port6DirReg      <= `MRI_PORT_DIR_RST;
			port7DirReg      <= `MRI_PORT_DIR_RST;
			port8DirReg      <= `MRI_PORT_DIR_RST;
			wakeupControlReg <= `MRI_ZERO_RST;
			timerControlReg  <= `MRI_TMR_CTL_RST;
			interruptMaskReg <= `MRI_ZERO_RST;
			wdtControlReg    <= `MRI_WDT_CTL_RST;
			ramPointerReg    <= `MRI_ZERO_RST;
			cnt1PeriodReg    <= `MRI_ZERO_RST;
			cnt2PeriodReg    <= `MRI_ZERO_RST;
			hpPeriodReg      <= `MRI_ZERO_RST;
			lpPeriodReg      <= `MRI_ZERO_RST;
			ackReg           <= 1'b0;
			rdataReg         <= 32'h00000000;
			wakeRestartReg   <= 1'b0;
		end else begin
			port5DirReg      <= port5DirNext;
			port6DirReg      <= port6DirNext;
			port7DirReg      <= port7DirNext;
			port8DirReg      <= port8DirNext;
			wakeupControlReg <= wakeCtlNext;
			timerControlReg  <= tmrCtlNext;
			interruptMaskReg <= intMaskNext;
			wdtControlReg    <= wdtCtlNext;
			ramPointerReg    <= ramPtrNext;
			cnt1PeriodReg    <= cnt1Next;
			cnt2PeriodReg    <= cnt2Next;
			hpPeriodReg      <= hpNext;
			lpPeriodReg      <= lpNext;
			ackReg           <= ackNext;
			rdataReg         <= rdataNext;
			wakeRestartReg   <= wakeRestartNext;
		end
	end

	assign watchdogEnable = wdtControlReg[`MRI_WDT_EN_BIT];
	assign wakeRestart    = wakeRestartReg;

	// ----------------------------------------
	// state kept across pin and watchdog resets
	// ----------------------------------------
	logic [7:0] ramWindowNext;
	logic [3:0] cpuBitsNext;
	mri_cause_t causeNext;

	always_comb begin
		ramWindowNext = wrByte(ramWindowReg, wrHit && idx == `MRI_IDX_RAM_WIN, wb_dat_i[7:0]);
		cpuBitsNext   = cpuBitsReg;
		if (wrHit && idx == `MRI_IDX_CPU_BITS) begin
			cpuBitsNext = wb_dat_i[3:0];
		end
		// the enable is sampled late on purpose: the request flop drives anySrc, is reset only by power-on and drops once its reset clears watchdogEnable
		wdtReqNext = wdtSync & watchdogEnable;
		causeNext  = causeReg;
		if (!pinSync) begin
			causeNext = MRI_CAUSE_PIN;
		end else if (wdtReqReg) begin
			causeNext = MRI_CAUSE_WDT;
		end else if (pinChangeWake) begin
			causeNext = MRI_CAUSE_WAKE;
		end
	end

	always_ff @(posedge mclk or negedge porRstB) begin
		if (!porRstB) begin
			ramWindowReg <= `MRI_ZERO_RST;
			cpuBitsReg   <= `MRI_CPU_BITS_RST;
			causeReg     <= MRI_CAUSE_POR;
			wdtReqReg    <= 1'b0;
		end else begin
			ramWindowReg <= ramWindowNext;
			cpuBitsReg   <= cpuBitsNext;
			causeReg     <= causeNext;
			wdtReqReg    <= wdtReqNext;
		end
	end

	assign cpuRegThreeBits = cpuBitsReg[1:0];
	assign cpuRegFourBits  = cpuBitsReg[3:2];
	assign resetCause      = causeReg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking mriCk @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence pinLowSeq;
		!pinSync;
	endsequence

	sequence releasedSeq;
		$rose(anyRstB);
	endsequence

	pin_reset_a: assert property (pinLowSeq |=> !coreResetB)
		else $error("pin low did not reset core");
	por_unmasked_a: assert property (porDetect |=> !coreResetB && !porRstB)
		else $error("power-on did not reset core");
	wdt_enabled_a: assert property (wdtSync && watchdogEnable |-> ##2 !coreResetB)
		else $error("enabled watchdog timeout did not reset");
	wdt_disabled_a: assert property ((wdtSync && !watchdogEnable) |=> !wdtReqReg)
		else $error("disabled watchdog raised reset");
	sync_release_a: assert property (releasedSeq |-> !$past(anySrc) && !$past(anySrc, 2))
		else $error("reset released too early");
	reset_effects_a: assert property (!coreResetB |-> programCounterClear && counterClear
		&& oscRunForce)
		else $error("reset effects missing");
	port_input_a: assert property (releasedSeq |-> port6DirReg == `MRI_PORT_DIR_RST
		&& port8DirReg == `MRI_PORT_DIR_RST && port5DirReg == `MRI_PORT5_RST)
		else $error("ports not inputs after reset");
	tmr_ctl_a: assert property (releasedSeq |-> timerControlReg == `MRI_TMR_CTL_RST)
		else $error("timer control wrong after reset");
	por_bits_a: assert property ($rose(porRstB) |-> cpuBitsReg == `MRI_CPU_BITS_RST)
		else $error("power-on did not clear cpu bits");
	warm_keep_a: assert property (!coreResetB && porRstB && $past(porRstB)
		|-> $stable(cpuBitsReg))
		else $error("warm reset changed cpu bits");
	wake_keep_a: assert property (pinChangeWake && coreResetB && !wrHit
		|=> wakeRestart && $stable(port6DirReg) && $stable(timerControlReg[5:0]))
		else $error("wake changed registers");

endmodule : mri_reset_initializer

/* mri_core_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// core and counter model at the reset outputs
// ----------------------------------------
module mri_core_model (
	input  wire logic       mclk,
	input  wire logic       programCounterClear,
	input  wire logic       counterClear,
	output logic      [7:0] pcValue,
	output logic      [7:0] tccValue
);
	// clears are levels: zero is held for the whole reset, counting resumes after it
	always_ff @(posedge mclk or posedge programCounterClear) begin
		if (programCounterClear) pcValue <= 8'h00;
		else pcValue <= pcValue + 8'h01;
	end
	always_ff @(posedge mclk or posedge counterClear) begin
		if (counterClear) tccValue <= 8'h00;
		else tccValue <= tccValue + 8'h01;
	end
endmodule : mri_core_model

/* tb_mri_reset_initializer.sv */
`timescale 1ns/1ps
`include "mri_defs.svh"

module tb_mri_reset_initializer;
	import mri_pkg::*;
	logic        mclk, rst_b, porDetect, resetPinB, wdtTimeout, pinChangeWake, timerIntEvent;
	logic        cyc, stb, we, ack, coreResetB, pcClr, cntClr, oscRun, wakeRestart, wdtEn;
	logic [7:0]  adr, p5, p6, p7, p8, wakeCtl, tmrCtl, intMask, pc, time_clock_counter, rdVal;
	logic [3:0]  sel;
	logic [31:0] datW, datR;
	logic [1:0]  cpu3, cpu4;
	mri_cause_t  cause;
	int          numErrors, totalChecks;

	mri_reset_initializer DUT (.mclk(mclk), .rst_b(rst_b), .porDetect(porDetect),
		.resetPinB(resetPinB), .wdtTimeout(wdtTimeout), .pinChangeWake(pinChangeWake),
		.timerIntEvent(timerIntEvent), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
		.coreResetB(coreResetB), .programCounterClear(pcClr), .counterClear(cntClr),
		.oscRunForce(oscRun), .wakeRestart(wakeRestart), .resetCause(cause),
		.port5DirReg(p5), .port6DirReg(p6), .port7DirReg(p7), .port8DirReg(p8),
		.wakeupControlReg(wakeCtl), .timerControlReg(tmrCtl), .interruptMaskReg(intMask),
		.watchdogEnable(wdtEn), .cpuRegThreeBits(cpu3), .cpuRegFourBits(cpu4));

	mri_core_model CORE (.mclk(mclk), .programCounterClear(pcClr), .counterClear(cntClr),
		.pcValue(pc), .tccValue(time_clock_counter));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] expV, input logic [31:0] gotV);
		totalChecks++;
		if (gotV !== expV) begin
			numErrors++;
			$display("MISMATCH %s expected %h seen %h", nm, expV, gotV);
		end
	endtask : chk

	// classic cycle: hold until ack is sampled high, then release
	task automatic wb(input logic wr, input logic [4:0] idx, input logic [7:0] d,
		input logic [3:0] s = 4'h1);
		int n;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		sel <= s;
		adr <= {1'b0, idx, 2'b00};
		datW <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 16);
		rdVal = datR[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			chk("ack", 1'b1, ack);
			end_of_test();
		end
	endtask : wb

	task automatic rd(input logic [4:0] idx, input logic [7:0] e, input string nm);
		wb(1'b0, idx, 8'h00);
		chk(nm, e, rdVal);
	endtask : rd

	task automatic waitCore(input logic lvl);
		int n;
		n = 0;
		while (coreResetB !== lvl && n < 20) begin
			@(posedge mclk);
			n++;
		end
		if (coreResetB !== lvl) begin
			chk("coreResetB", lvl, coreResetB);
			end_of_test();
		end
	endtask : waitCore

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic testResetValues;
		rd(`MRI_IDX_PORT5_DIR, 8'hF0, "port5");
		rd(`MRI_IDX_PORT6_DIR, 8'hFF, "port6");
		rd(`MRI_IDX_PORT7_DIR, 8'hFF, "port7");
		rd(`MRI_IDX_PORT8_DIR, 8'hFF, "port8");
		rd(`MRI_IDX_TMR_CTL, 8'hBF, "tmrCtl");
		rd(`MRI_IDX_WAKE_CTL, 8'h00, "wakeCtl");
		rd(`MRI_IDX_INT_MASK, 8'h00, "intMask");
		rd(`MRI_IDX_WDT_CTL, 8'h07, "wdtCtl");
		rd(`MRI_IDX_CNT1_PER, 8'h00, "cnt1Per");
		wb(1'b1, 5'h1F, 8'hAA);
		rd(5'h1F, 8'h00, "unmapped");
		wb(1'b1, `MRI_IDX_PORT5_DIR, 8'h00, 4'hE);
		rd(`MRI_IDX_PORT5_DIR, 8'hF0, "selOff");
	endtask : testResetValues

	task automatic testPor;
		// set the power-on-only state first so that its clearing is visible
		wb(1'b1, `MRI_IDX_CPU_BITS, 8'h0F);
		wb(1'b1, `MRI_IDX_RAM_WIN, 8'h5A);
		rd(`MRI_IDX_CPU_BITS, 8'h0F, "cpuBitsSet");
		@(posedge mclk);
		pinChangeWake <= 1'b1;
		@(posedge mclk);
		pinChangeWake <= 1'b0;
		@(posedge mclk);
		porDetect <= 1'b1;
		#1;
		chk("asyncCore", 1'b0, coreResetB);
		repeat (2) @(posedge mclk);
		#1;
		chk("oscRunForce", 1'b1, oscRun);
		chk("pcValue", 8'h00, pc);
		chk("tccValue", 8'h00, time_clock_counter);
		@(posedge mclk);
		porDetect <= 1'b0;
		waitCore(1'b1);
		rd(`MRI_IDX_CPU_BITS, 8'h00, "cpuBitsPor");
		chk("cpu3Por", 2'b00, cpu3);
		chk("cpu4Por", 2'b00, cpu4);
		rd(`MRI_IDX_RAM_WIN, 8'h00, "ramWinPor");
		rd(`MRI_IDX_CAUSE, 8'h00, "causePor");
	endtask : testPor

	task automatic testPinReset;
		wb(1'b1, `MRI_IDX_PORT5_DIR, 8'h12);
		wb(1'b1, `MRI_IDX_PORT6_DIR, 8'h34);
		wb(1'b1, `MRI_IDX_PORT7_DIR, 8'h56);
		wb(1'b1, `MRI_IDX_PORT8_DIR, 8'h78);
		wb(1'b1, `MRI_IDX_INT_MASK, 8'hFF);
		wb(1'b1, `MRI_IDX_WAKE_CTL, 8'h8F);
		wb(1'b1, `MRI_IDX_TMR_CTL, 8'h00);
		wb(1'b1, `MRI_IDX_CPU_BITS, 8'h0F);
		wb(1'b1, `MRI_IDX_RAM_WIN, 8'hA5);
		@(posedge mclk);
		timerIntEvent <= 1'b1;
		@(posedge mclk);
		timerIntEvent <= 1'b0;
		rd(`MRI_IDX_TMR_CTL, 8'h40, "tmrFlag");
		@(posedge mclk);
		resetPinB <= 1'b0;
		waitCore(1'b0);
		#1;
		chk("p5Rst", 8'hF0, p5);
		chk("p6Rst", 8'hFF, p6);
		chk("p7Rst", 8'hFF, p7);
		chk("p8Rst", 8'hFF, p8);
		chk("tmrRst", 8'hBF, tmrCtl);
		chk("maskRst", 8'h00, intMask);
		chk("wakeRst", 8'h00, wakeCtl);
		@(posedge mclk);
		resetPinB <= 1'b1;
		waitCore(1'b1);
		rd(`MRI_IDX_CPU_BITS, 8'h0F, "cpuBitsPin");
		chk("cpu3Pin", 2'b11, cpu3);
		chk("cpu4Pin", 2'b11, cpu4);
		rd(`MRI_IDX_RAM_WIN, 8'hA5, "ramWinPin");
		rd(`MRI_IDX_CAUSE, 8'h01, "causePin");
	endtask : testPinReset

	task automatic testWatchdog;
		@(posedge mclk);
		wdtTimeout <= 1'b1;
		repeat (8) begin
			@(posedge mclk);
			chk("wdtOff", 1'b1, coreResetB);
		end
		wdtTimeout <= 1'b0;
		wb(1'b1, `MRI_IDX_WDT_CTL, 8'h0F);
		// the write lands at the ack edge; look once it has settled
		#1;
		chk("wdtEnable", 1'b1, wdtEn);
		@(posedge mclk);
		wdtTimeout <= 1'b1;
		waitCore(1'b0);
		@(posedge mclk);
		wdtTimeout <= 1'b0;
		waitCore(1'b1);
		rd(`MRI_IDX_CAUSE, 8'h02, "causeWdt");
		rd(`MRI_IDX_WDT_CTL, 8'h07, "wdtCtlRst");
	endtask : testWatchdog

	task automatic testWake;
		wb(1'b1, `MRI_IDX_PORT6_DIR, 8'h55);
		@(posedge mclk);
		pinChangeWake <= 1'b1;
		@(posedge mclk);
		pinChangeWake <= 1'b0;
		#1;
		chk("wakeRestart", 1'b1, wakeRestart);
		chk("wakeCore", 1'b1, coreResetB);
		chk("p6Kept", 8'h55, p6);
		chk("causeWakeOut", 2'b11, cause);
		rd(`MRI_IDX_CAUSE, 8'h03, "causeWake");
	endtask : testWake

	// ----------------------------------------
	// clock and main sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	initial begin
		rst_b = 1'b0;
		porDetect = 1'b0;
		resetPinB = 1'b1;
		wdtTimeout = 1'b0;
		pinChangeWake = 1'b0;
		timerIntEvent = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'h1;
		adr = 8'h00;
		datW = 32'h00000000;
		numErrors = 0;
		totalChecks = 0;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		waitCore(1'b1);
		testResetValues();
		testPor();
		testPinReset();
		testWatchdog();
		testWake();
		end_of_test();
	end
endmodule : tb_mri_reset_initializer
